/* design/ssw_params.svh */
// Offsets, field positions, reset values and timing counts of the slave watchdog block
`ifndef SSW_PARAMS_SVH
`define SSW_PARAMS_SVH
// ==========================================================
// Register byte offsets
`define SSW_OFF_CTRL   8'h00
`define SSW_OFF_STATUS 8'h04
`define SSW_OFF_MULT   8'h08
`define SSW_OFF_NET_TO 8'h0c
`define SSW_OFF_APP_TO 8'h10
`define SSW_OFF_OUT    8'h14
`define SSW_OFF_IN     8'h18
// ==========================================================
// Status fields
`define SSW_ST_ERR     4
`define SSW_ST_NET_EXP 5
`define SSW_ST_APP_EXP 6
`define SSW_ST_OUT_VAL 7
// ==========================================================
// Reset values
`define SSW_MULT_RST   16'h09c2
`define SSW_NET_TO_RST 16'h03e8
`define SSW_APP_TO_RST 16'h03e8
`define SSW_MULT_MIN   16'h0001
`define SSW_WD_DEF_MS  100
// ==========================================================
// Timing
`define SSW_CLK_NS     20
`define SSW_BASE_NS    40
`define SSW_BASE_CYC   ((`SSW_BASE_NS + `SSW_CLK_NS - 1) / `SSW_CLK_NS)
`endif

/* design/ssw_pkg.sv */
// Types shared by the slave watchdog block
package ssw_pkg;
    typedef enum logic [2:0] {
        SSW_INIT   = 3'h0,
        SSW_PREOP  = 3'h1,
        SSW_SAFEOP = 3'h3,
        SSW_OP     = 3'h2,
        SSW_BOOT   = 3'h4
    } ssw_state_e;

    typedef struct packed {
        logic [15:0] mult;
        logic [15:0] net_to;
        logic [15:0] app_to;
    } ssw_cfg_s;

    typedef struct packed {
        logic mbx;
        logic pd;
        logic dc;
        logic outv;
    } ssw_chk_s;
endpackage

/* design/ssw_watchdog.sv */
// Slave state machine with network-side and application-side watchdogs
//
// Notes on behaviour
// R1: Two independent watchdogs, network and application, each default 100 ms.
// R2: Network watchdog restarts only on a successful process data exchange.
// R3: Network watchdog expiry drives all outputs false.
// R4: Network watchdog expiry leaves the operating state unchanged.
// R5: Application watchdog flags expiry when no local access occurs in time.
// R6: One shared multiplier; each watchdog has its own count times the tick.
// R7: Master writes multiplier and timeouts only when manual setting is chosen; the code accepts these writes at any time, in every state.
// R8: One tick lasts multiplier plus two periods of the 40 ns base clock.
// R9: Multiplier resets to 2498, a tick of 100 us.
// R10: Network timeout count resets to 1000 ticks, 100 ms by default.
// R11: Timeouts 0 to 65535 and multipliers 1 to 65535 are accepted.
// R12: Network timeout count 0 disables that watchdog completely.
// R13: After reset the state is init; mailbox and process data refused.
// R14: In init the master sets up sync channels 0 and 1 for mailbox.
// R15: Init to pre-operational needs a valid mailbox setup.
// R16: Pre-operational allows mailbox, blocks process data.
// R17: In pre-operational the master sets up process data and mapping.
// R18: To safe-operational needs channel and clock checks; inputs copied first.
// R19: Safe-operational allows both traffic kinds, inputs cyclic, outputs safe.
// R20: Master delivers valid output data before asking for operational.
// R21: Operational copies master output data to physical outputs.
// R22: Boot only from init; only file-transfer mailbox traffic there.
// R23: Watchdogs count ticks, expire at the timeout, clear on access.
`timescale 1ns/100ps
`default_nettype none
`include "ssw_params.svh"
module ssw_watchdog import ssw_pkg::*; (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Network side traffic
    input  wire logic        pd_req,
    input  wire logic        pd_done,
    input  wire logic [31:0] net_out_data,
    input  wire logic        mbx_req,
    input  wire logic        mbx_is_foe,
    output logic             pd_ack,
    output logic             pd_nak,
    output logic             mbx_ack,
    output logic             mbx_nak,
    // Configuration checks
    input  wire logic        mbx_cfg_ok,
    input  wire logic        pd_cfg_ok,
    input  wire logic        dc_cfg_ok,
    // Local process data interface
    input  wire logic        app_access,
    // Physical pins
    input  wire logic [31:0] phys_in,
    output logic [31:0]      phys_out,
    output logic             net_wd_expired,
    output logic             app_wd_expired
);
    // ==========================================================
    // Helpers
    function automatic logic [17:0] tick_len(input logic [15:0] m);
        logic [17:0] s;
        s = {2'h0, m} + 18'h2;
        tick_len = 18'(s * `SSW_BASE_CYC);
    endfunction

    function automatic logic move_ok(input ssw_state_e c, input logic [2:0] r,
                                     input ssw_chk_s k);
        move_ok = 1'b0;
        unique case (c)
            SSW_INIT:   move_ok = r == SSW_INIT || r == SSW_BOOT ||
                                  (r == SSW_PREOP && k.mbx);
            SSW_PREOP:  move_ok = r == SSW_INIT || r == SSW_PREOP ||
                                  (r == SSW_SAFEOP && k.pd && k.dc);
            SSW_SAFEOP: move_ok = r == SSW_INIT || r == SSW_PREOP ||
                                  r == SSW_SAFEOP || (r == SSW_OP && k.outv);
            SSW_OP:     move_ok = r == SSW_INIT || r == SSW_PREOP ||
                                  r == SSW_SAFEOP || r == SSW_OP;
            SSW_BOOT:   move_ok = r == SSW_INIT || r == SSW_BOOT;
            default:    move_ok = 1'b0;
        endcase
    endfunction

    ssw_state_e  state_q;
    ssw_cfg_s    cfg_q;
    ssw_chk_s    chk;
    logic [17:0] presc_q;
    logic        tick;
    logic [15:0] net_cnt_q;
    logic [15:0] app_cnt_q;
    logic        net_exp_q;
    logic        app_exp_q;
    logic        err_q;
    logic        outv_q;
    logic [31:0] out_data_q;
    logic [31:0] dpm_in_q;
    logic [31:0] in_m_q;
    logic [31:0] in_s2_q;
    logic [31:0] in_s3_q;
    logic [31:0] in_q;
    logic        pready_q;
    logic        pslverr_q;
    logic [31:0] prdata_q;
    logic        wr;
    logic        wr_ctrl;
    logic        ctrl_ok;
    logic        pd_allow;
    logic        mbx_allow;
    logic        pd_good;
    logic        to_safeop;

    assign wr        = psel && penable && pready_q && pwrite;
    assign wr_ctrl   = wr && paddr == `SSW_OFF_CTRL;
    assign chk       = '{mbx: mbx_cfg_ok, pd: pd_cfg_ok, dc: dc_cfg_ok, outv: outv_q};
    assign ctrl_ok   = move_ok(state_q, pwdata[2:0], chk);
    assign to_safeop = wr_ctrl && ctrl_ok && state_q == SSW_PREOP &&
                       pwdata[2:0] == SSW_SAFEOP;
    assign pd_allow  = state_q == SSW_SAFEOP || state_q == SSW_OP;
    assign mbx_allow = state_q == SSW_PREOP || pd_allow ||
                       (state_q == SSW_BOOT && mbx_is_foe);
    assign pd_good   = pd_done && pd_allow;
    assign tick      = presc_q == tick_len(cfg_q.mult) - 18'h1;

    // ==========================================================
    // APB slave: one wait-free access phase, answer prepared in setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0;
        end else begin
            pready_q  <= psel && !penable;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0;
            if (psel && !penable) begin
                unique case (paddr)
                    `SSW_OFF_CTRL:   prdata_q <= {29'h0, state_q};
                    `SSW_OFF_STATUS: prdata_q <= {24'h0, outv_q, app_exp_q, net_exp_q,
                                                  err_q, 1'b0, state_q};
                    `SSW_OFF_MULT:   prdata_q <= {16'h0, cfg_q.mult};
                    `SSW_OFF_NET_TO: prdata_q <= {16'h0, cfg_q.net_to};
                    `SSW_OFF_APP_TO: prdata_q <= {16'h0, cfg_q.app_to};
                    `SSW_OFF_OUT:    prdata_q <= out_data_q;
                    `SSW_OFF_IN:     prdata_q <= dpm_in_q;
                    default:         pslverr_q <= 1'b1;
                endcase
            end
        end
    end

    // ==========================================================
    // Watchdog settings; a zero multiplier is raised to the least legal one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= '{mult: `SSW_MULT_RST, net_to: `SSW_NET_TO_RST,
                       app_to: `SSW_APP_TO_RST};                        // [R1] [R9] [R10]
        end else if (wr && !pslverr_q) begin
            if (paddr == `SSW_OFF_MULT)
                cfg_q.mult <= (pwdata[15:0] == 16'h0) ? `SSW_MULT_MIN : pwdata[15:0]; // [R11]
            if (paddr == `SSW_OFF_NET_TO)
                cfg_q.net_to <= pwdata[15:0];                           // [R11]
            if (paddr == `SSW_OFF_APP_TO)
                cfg_q.app_to <= pwdata[15:0];
        end
    end

    // ==========================================================
    // Shared prescaler
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            presc_q <= 18'h0;
        else if (presc_q >= tick_len(cfg_q.mult) - 18'h1)
            presc_q <= 18'h0;                                           // [R6] [R8]
        else
            presc_q <= presc_q + 18'h1;
    end

    // ==========================================================
    // Network-side watchdog
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            net_cnt_q <= 16'h0;
            net_exp_q <= 1'b0;
        end else begin
            if (pd_good)
                net_cnt_q <= 16'h0;                                     // [R2] [R23]
            else if (tick && net_cnt_q < cfg_q.net_to)
                net_cnt_q <= net_cnt_q + 16'h1;                         // [R6] [R23]
            net_exp_q <= !pd_good && cfg_q.net_to != 16'h0 &&
                         net_cnt_q >= cfg_q.net_to;                     // [R12] [R23]
        end
    end

    // ==========================================================
    // Application-side watchdog
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            app_cnt_q <= 16'h0;
            app_exp_q <= 1'b0;
        end else begin
            if (app_access)
                app_cnt_q <= 16'h0;                                     // [R23]
            else if (tick && app_cnt_q < cfg_q.app_to)
                app_cnt_q <= app_cnt_q + 16'h1;                         // [R6]
            app_exp_q <= !app_access && cfg_q.app_to != 16'h0 &&
                         app_cnt_q >= cfg_q.app_to;                     // [R5]
        end
    end

    // ==========================================================
    // Slave state machine; watchdog expiry is deliberately not an input
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            state_q <= SSW_INIT;                                        // [R13]
        else if (wr_ctrl && ctrl_ok)
            state_q <= ssw_state_e'(pwdata[2:0]);                       // [R4] [R15] [R18] [R22]
    end

    // Refused moves raise a sticky error; a new refusal beats a clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            err_q <= 1'b0;
        else if (wr_ctrl && !ctrl_ok)
            err_q <= 1'b1;
        else if (wr && paddr == `SSW_OFF_STATUS && pwdata[`SSW_ST_ERR])
            err_q <= 1'b0;
    end

    // Output data seen in safe-operational enables the move to operational
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            outv_q <= 1'b0;
        else if (!pd_allow)
            outv_q <= 1'b0;
        else if (pd_good)
            outv_q <= 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            out_data_q <= 32'h0;
        else if (pd_good)
            out_data_q <= net_out_data;
    end

    // ==========================================================
    // Traffic gating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pd_ack  <= 1'b0;
            pd_nak  <= 1'b0;
            mbx_ack <= 1'b0;
            mbx_nak <= 1'b0;
        end else begin
            pd_ack  <= pd_req && pd_allow;                              // [R19] [R21]
            pd_nak  <= pd_req && !pd_allow;                             // [R13] [R16]
            mbx_ack <= mbx_req && mbx_allow;                            // [R16] [R22]
            mbx_nak <= mbx_req && !mbx_allow;                           // [R13] [R22]
        end
    end

    // ==========================================================
    // Input pins: three stages, a change counts once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_m_q  <= 32'h0;
            in_s2_q <= 32'h0;
            in_s3_q <= 32'h0;
            in_q    <= 32'h0;
        end else begin
            in_m_q  <= phys_in;
            in_s2_q <= in_m_q;
            in_s3_q <= in_s2_q;
            if (in_s2_q == in_s3_q)
                in_q <= in_s3_q;
        end
    end

    // Input image: captured before safe-operational is entered, then cyclic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            dpm_in_q <= 32'h0;
        else if (to_safeop || pd_good)
            dpm_in_q <= in_q;                                           // [R18] [R19]
    end

    // ==========================================================
    // Physical outputs follow master data only in operational and alive
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            phys_out <= 32'h0;
        else if (state_q == SSW_OP && !net_exp_q)
            phys_out <= out_data_q;                                     // [R21]
        else
            phys_out <= 32'h0;                                          // [R3] [R19]
    end

    assign pready         = pready_q;
    assign prdata         = prdata_q;
    assign pslverr        = pslverr_q;
    assign net_wd_expired = net_exp_q;
    assign app_wd_expired = app_exp_q;

    // ==========================================================
    // Checks
    a_out_forced_safe: assert property (@(posedge pclk) disable iff (!presetn)
        net_exp_q |=> phys_out == 32'h0) else $error("outputs not safe on expiry"); // [R3]
    a_state_kept: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(net_exp_q) && state_q == SSW_OP && !wr_ctrl |-> ##1 state_q == SSW_OP)
        else $error("expiry changed the state"); // [R4]
    a_net_restart: assert property (@(posedge pclk) disable iff (!presetn)
        pd_good |=> net_cnt_q == 16'h0 && !net_exp_q) else $error("no restart"); // [R2]
    a_net_disabled: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_q.net_to == 16'h0 |=> !net_exp_q) else $error("disabled dog fired"); // [R12]
    a_app_flag: assert property (@(posedge pclk) disable iff (!presetn)
        app_cnt_q >= cfg_q.app_to && cfg_q.app_to != 16'h0 && !app_access |=> app_exp_q)
        else $error("app expiry missed"); // [R5]
    a_tick_spacing: assert property (@(posedge pclk) disable iff (!presetn)
        tick |=> !tick [*5]) else $error("tick too short"); // [R8]
    a_init_refuse: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == SSW_INIT && (pd_req || mbx_req) |=> !pd_ack && !mbx_ack)
        else $error("init accepted traffic"); // [R13]
    a_preop_gate: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == SSW_PREOP && pd_req && mbx_req |=> pd_nak && mbx_ack)
        else $error("preop gating wrong"); // [R16]
    a_boot_foe: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == SSW_BOOT && mbx_req |=> mbx_ack == $past(mbx_is_foe))
        else $error("boot mailbox gating wrong"); // [R22]
    a_preop_guard: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == SSW_INIT ##1 state_q == SSW_PREOP |-> $past(mbx_cfg_ok))
        else $error("preop entered without mailbox"); // [R15]
    a_op_follow: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == SSW_OP && !net_exp_q |=> phys_out == $past(out_data_q))
        else $error("outputs not following"); // [R21]
endmodule
`default_nettype wire

/* tb/ssw_net_master.sv */
// Network master model driving traffic pulses and configuration outcome
`timescale 1ns/100ps
`default_nettype none
module ssw_net_master (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Traffic to the slave
    output logic             pd_req,
    output logic             pd_done,
    output logic [31:0]      net_out_data,
    output logic             mbx_req,
    output logic             mbx_is_foe,
    // Answers from the slave
    input  wire logic        pd_ack,
    input  wire logic        pd_nak,
    input  wire logic        mbx_ack,
    input  wire logic        mbx_nak,
    // Configuration outcome
    output logic             mbx_cfg_ok,
    output logic             pd_cfg_ok,
    output logic             dc_cfg_ok
);
    initial begin
        {pd_req, pd_done, mbx_req, mbx_is_foe} = 4'h0;
        net_out_data = 32'h0;
        {mbx_cfg_ok, pd_cfg_ok, dc_cfg_ok} = 3'h0;
    end
    // Mailbox channels 0/1 set in init, process data channels from 2 in preop
    task automatic setup(input logic mbx, input logic pd, input logic dc);
        @(posedge pclk);
        mbx_cfg_ok <= mbx;
        pd_cfg_ok  <= pd;
        dc_cfg_ok  <= dc;
    endtask
    // One request pulse; the answer stands in the following cycle
    task automatic request(input logic is_pd, input logic file_transfer_mailbox, output logic [1:0] ans);
        @(posedge pclk);
        pd_req     <= is_pd;
        mbx_req    <= ~is_pd;
        mbx_is_foe <= file_transfer_mailbox;
        @(posedge pclk);
        pd_req     <= 1'b0;
        mbx_req    <= 1'b0;
        mbx_is_foe <= ~file_transfer_mailbox;
        @(posedge pclk);
        ans = is_pd ? {pd_ack, pd_nak} : {mbx_ack, mbx_nak};
    endtask
    // Completed exchange; the data line is scrambled once released
    task automatic exchange(input logic [31:0] data);
        @(posedge pclk);
        pd_done      <= 1'b1;
        net_out_data <= data;
        @(posedge pclk);
        pd_done      <= 1'b0;
        net_out_data <= ~data;
    endtask
endmodule
`default_nettype wire

/* tb/ssw_watchdog_bench.sv */
// Self-checking testbench of the slave state and watchdog block
`timescale 1ns/100ps
`default_nettype none
`include "ssw_params.svh"
module ssw_watchdog_bench;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, app_access;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, net_out_data, phys_in, phys_out;
    logic        pd_req, pd_done, mbx_req, mbx_is_foe, pd_ack, pd_nak, mbx_ack;
    logic        mbx_nak, mbx_cfg_ok, pd_cfg_ok, dc_cfg_ok, net_wd_expired, app_wd_expired;
    int          errors, checked;
    localparam logic [1:0]  ACK = 2'h2, NAK = 2'h1;
    localparam logic [31:0] ALL = 32'hffff_ffff, LOW5 = 32'h1f, ST = 32'h7;

    ssw_watchdog DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .pd_req, .pd_done, .net_out_data, .mbx_req,
        .mbx_is_foe, .pd_ack, .pd_nak, .mbx_ack, .mbx_nak, .mbx_cfg_ok, .pd_cfg_ok,
        .dc_cfg_ok, .app_access, .phys_in, .phys_out, .net_wd_expired, .app_wd_expired);
    ssw_net_master m (.pclk, .presetn, .pd_req, .pd_done, .net_out_data, .mbx_req,
        .mbx_is_foe, .pd_ack, .pd_nak, .mbx_ack, .mbx_nak, .mbx_cfg_ok, .pd_cfg_ok,
        .dc_cfg_ok);

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // ==========================================================
    // Shared tasks
    task automatic chk(input string w, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", w, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask
    // Answer taken at the rising edge that samples pready high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rdc(input string w, input logic [7:0] a, input logic [31:0] msk,
                       input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(w, r & msk, exp);
    endtask
    task automatic req(input string w, input logic pd, input logic file_transfer_mailbox, input logic [1:0] exp);
        logic [1:0] a;
        m.request(pd, file_transfer_mailbox, a);
        chk(w, a, exp);
    endtask
    task automatic poke();
        @(posedge pclk);
        app_access <= 1'b1;
        @(posedge pclk);
        app_access <= 1'b0;
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_reset();
        logic [31:0] r;
        logic        e;
        rdc("state", `SSW_OFF_CTRL, ALL, 32'h0);
        rdc("mult", `SSW_OFF_MULT, ALL, 32'h9c2);
        rdc("net to", `SSW_OFF_NET_TO, ALL, 32'h3e8);
        rdc("app to", `SSW_OFF_APP_TO, ALL, 32'h3e8);
        req("pd init", 1'b1, 1'b0, NAK);
        req("mbx init", 1'b0, 1'b0, NAK);
        apb(1'b0, 8'h40, 32'h0, r, e);
        chk("unmapped", e, 32'h1);
        $display("test reset done");
    endtask
    task automatic t_states();
        wr(`SSW_OFF_CTRL, 32'h1);
        rdc("no mbx cfg", `SSW_OFF_STATUS, LOW5, 32'h10);
        wr(`SSW_OFF_STATUS, 32'h10);
        m.setup(1'b1, 1'b0, 1'b0);
        wr(`SSW_OFF_CTRL, 32'h1);
        rdc("preop", `SSW_OFF_STATUS, LOW5, 32'h1);
        req("mbx preop", 1'b0, 1'b0, ACK);
        req("pd preop", 1'b1, 1'b0, NAK);
        phys_in <= 32'h5a5a_0f0f;
        wr(`SSW_OFF_CTRL, 32'h3);
        rdc("no pd cfg", `SSW_OFF_STATUS, LOW5, 32'h11);
        wr(`SSW_OFF_STATUS, 32'h10);
        m.setup(1'b1, 1'b1, 1'b1);
        wr(`SSW_OFF_CTRL, 32'h3);
        rdc("safeop", `SSW_OFF_CTRL, ST, 32'h3);
        rdc("in copy", `SSW_OFF_IN, ALL, 32'h5a5a_0f0f);
        req("pd safeop", 1'b1, 1'b0, ACK);
        req("mbx safeop", 1'b0, 1'b0, ACK);
        phys_in <= 32'h1234_8765;
        cyc(6);
        m.exchange(32'hc3c3_1234);
        cyc(2);
        chk("safe out", phys_out, 32'h0);
        rdc("in cyclic", `SSW_OFF_IN, ALL, 32'h1234_8765);
        wr(`SSW_OFF_CTRL, 32'h2);
        rdc("op", `SSW_OFF_CTRL, ST, 32'h2);
        cyc(2);
        chk("op out", phys_out, 32'hc3c3_1234);
        req("pd op", 1'b1, 1'b0, ACK);
        req("mbx op", 1'b0, 1'b0, ACK);
        $display("test states done");
    endtask
    task automatic t_net_wd();
        logic [15:0] mul [2] = '{16'h1, 16'h3};
        int          t;
        // No manual setting choice exists; the settings are loaded on every write
        wr(`SSW_OFF_NET_TO, 32'h3);
        for (int k = 0; k < 2; k++) begin
            t = 2 * (mul[k] + 2);
            wr(`SSW_OFF_MULT, {16'h0, mul[k]});
            m.exchange(32'h0000_00a5);
            cyc(2 * t - 2);
            chk("early", net_wd_expired, 32'h0);
            cyc(t + 4);
            chk("expired", net_wd_expired, 32'h1);
            chk("safe pins", phys_out, 32'h0);
            rdc("still op", `SSW_OFF_CTRL, ST, 32'h2);
        end
        rdc("net flag", `SSW_OFF_STATUS, 32'h20, 32'h20);
        req("pd only", 1'b1, 1'b0, ACK);
        cyc(1);
        chk("no restart", net_wd_expired, 32'h1);
        m.exchange(32'h0000_0f0f);
        cyc(2);
        chk("restart", net_wd_expired, 32'h0);
        chk("pins back", phys_out, 32'h0f0f);
        wr(`SSW_OFF_NET_TO, 32'h0);
        m.exchange(32'h0000_3c3c);
        cyc(150);
        chk("disabled", net_wd_expired, 32'h0);
        chk("pins kept", phys_out, 32'h3c3c);
        $display("test network watchdog done");
    endtask
    task automatic t_limits();
        wr(`SSW_OFF_MULT, 32'hffff);
        rdc("mult max", `SSW_OFF_MULT, ALL, 32'hffff);
        wr(`SSW_OFF_MULT, 32'h0);
        rdc("mult min", `SSW_OFF_MULT, ALL, 32'h1);
        wr(`SSW_OFF_NET_TO, 32'hffff);
        rdc("to max", `SSW_OFF_NET_TO, ALL, 32'hffff);
        $display("test limits done");
    endtask
    task automatic t_app_wd();
        wr(`SSW_OFF_APP_TO, 32'h3);
        repeat (6) begin
            poke();
            cyc(8);
            chk("fed", app_wd_expired, 32'h0);
        end
        poke();
        cyc(10);
        chk("app early", app_wd_expired, 32'h0);
        cyc(11);
        chk("app expired", app_wd_expired, 32'h1);
        rdc("app flag", `SSW_OFF_STATUS, 32'h40, 32'h40);
        poke();
        cyc(2);
        chk("app clear", app_wd_expired, 32'h0);
        $display("test app watchdog done");
    endtask
    task automatic t_boot();
        wr(`SSW_OFF_CTRL, 32'h0);
        wr(`SSW_OFF_CTRL, 32'h4);
        rdc("boot", `SSW_OFF_CTRL, ST, 32'h4);
        req("foe", 1'b0, 1'b1, ACK);
        req("mbx boot", 1'b0, 1'b0, NAK);
        req("pd boot", 1'b1, 1'b0, NAK);
        wr(`SSW_OFF_CTRL, 32'h1);
        rdc("boot exit", `SSW_OFF_STATUS, LOW5, 32'h14);
        wr(`SSW_OFF_STATUS, 32'h10);
        wr(`SSW_OFF_CTRL, 32'h0);
        wr(`SSW_OFF_CTRL, 32'h1);
        wr(`SSW_OFF_CTRL, 32'h4);
        rdc("boot from preop", `SSW_OFF_STATUS, LOW5, 32'h11);
        $display("test boot done");
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ==========================================================
    // Main sequence and watchdog
    initial begin
        {presetn, psel, penable, pwrite, app_access} = 5'h0;
        paddr   = 8'h0;
        pwdata  = 32'h0;
        phys_in = 32'h0;
        errors  = 0;
        checked = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_states();
        t_net_wd();
        t_limits();
        t_app_wd();
        t_boot();
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        $display("run limit reached");
        complete_run();
    end
endmodule
`default_nettype wire
